/* rtl/twu_pkg.sv */
// Package of the timing and watchdog unit: register map, field layout,
// reset values, power modes and the service match code.
// Assumes a 32-bit APB bus with one register per aligned word.
package twu_pkg;
  // Register indices; byte address is four times the index
  localparam logic [23:0] IDX_CONFIG = 24'hffff20; // Timer watchdog config
  localparam logic [23:0] IDX_PRESCALER = 24'hffff22; // Tick prescaler
  localparam logic [23:0] IDX_RELOAD = 24'hffff24; // Periodic reload value
  localparam logic [23:0] IDX_CTRL_STATUS = 24'hffff26; // Periodic control status
  localparam logic [23:0] IDX_WD_COUNT = 24'hffff28; // Watchdog count
  localparam logic [23:0] IDX_WD_MATCH = 24'hffff2a; // Watchdog service match
  // Byte addresses on the bus
  localparam logic [31:0] ADDR_CONFIG = {6'h00, IDX_CONFIG, 2'b00};
  localparam logic [31:0] ADDR_PRESCALER = {6'h00, IDX_PRESCALER, 2'b00};
  localparam logic [31:0] ADDR_RELOAD = {6'h00, IDX_RELOAD, 2'b00};
  localparam logic [31:0] ADDR_CTRL_STATUS = {6'h00, IDX_CTRL_STATUS, 2'b00};
  localparam logic [31:0] ADDR_WD_COUNT = {6'h00, IDX_WD_COUNT, 2'b00};
  localparam logic [31:0] ADDR_WD_MATCH = {6'h00, IDX_WD_MATCH, 2'b00};
  // Configuration fields
  localparam int CFG_LOCK_CONFIG = 0; // Locks config register
  localparam int CFG_LOCK_PRESCALER = 1; // Locks prescaler register
  localparam int CFG_LOCK_TIMER = 2; // Locks reload and control status
  localparam int CFG_LOCK_WD_COUNT = 3; // Locks watchdog count
  localparam int CFG_WD_CLOCK_SELECT = 4; // 1: prescaled clock, 0: tick pulse
  localparam int CFG_MATCH_SERVICE = 5; // 1: service by match code
  localparam int CFG_WIDTH = 6; // Implemented config bits
  // Control status fields
  localparam int CS_RESTART = 0; // Restart request
  localparam int CS_EXPIRED = 1; // Timer expired flag, write 1 clears
  localparam int CS_IRQ_ENABLE = 2; // Timer interrupt enable
  // Widths and reset values
  localparam int PRESCALE_WIDTH = 3; // Prescale select width
  localparam logic [5:0] CONFIG_RESET = 6'h00; // Config after reset
  localparam logic [2:0] PRESCALE_RESET = 3'h0; // Divide by one after reset
  localparam logic [15:0] RELOAD_RESET = 16'hffff; // Reload after reset
  localparam logic [7:0] WD_COUNT_RESET = 8'h00; // Watchdog count after reset
  localparam logic [7:0] SERVICE_CODE = 8'h5c; // Valid match service value
  localparam logic [31:0] UNDEF_READ = 32'h0000_0000; // Locked or barred read
  // Power modes on the power_mode input
  typedef enum logic [1:0] {
    TWU_ACTIVE = 2'b00,
    TWU_POWER_SAVE = 2'b01,
    TWU_IDLE = 2'b10,
    TWU_HALT = 2'b11
  } twu_mode_t;
endpackage

/* rtl/twu_prescaler.sv */
// Prescaler dividing slow clock edges into prescaled clock ticks.
// Assumes slow_edge is a one-cycle pulse already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none
module twu_prescaler (
  input wire logic clock, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic slow_edge, // One pulse per slow clock rising edge
  input wire logic [twu_pkg::PRESCALE_WIDTH-1:0] prescale_select, // Divisor select
  output logic prescaled_tick // One pulse per prescaled clock edge
);
  import twu_pkg::*;

  logic [4:0] div_count; // Free running slow edge counter

  // Mask of counter bits that must be all ones; reserved codes act as 32
  function automatic logic [4:0] div_mask(input logic [PRESCALE_WIDTH-1:0] sel);
    case (sel)
      3'h0: div_mask = 5'h00;
      3'h1: div_mask = 5'h01;
      3'h2: div_mask = 5'h03;
      3'h3: div_mask = 5'h07;
      3'h4: div_mask = 5'h0f;
      default: div_mask = 5'h1f;
    endcase
  endfunction

  // Count slow edges
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_count <= 5'h00;
    end else if (slow_edge) begin
      div_count <= div_count + 5'h01;
    end
  end

  // (R1) Divide by 1 to 32
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prescaled_tick <= 1'b0;
    end else begin
      prescaled_tick <= slow_edge &&
        ((div_count & div_mask(prescale_select)) == div_mask(prescale_select));
    end
  end
endmodule // twu_prescaler
`default_nettype wire

/* rtl/twu_timer_watchdog.sv */
// Periodic timer and watchdog with APB registers, locks and power modes.
// Assumes slow_clock is an asynchronous pin far slower than clock, and
// that watchdog_reset is wired back into the device reset.
// Operation
// (R1) Prescaler divides slow clock by 1..32
// (R2) 16-bit timer counts down per prescaled edge
// (R3) Auto reload at zero, period reload plus one
// (R4) Software programs reload 0001h to FFFFh only
// (R5) Tick pulse lasts one prescaled clock
// (R6) Tick sets flag, interrupt when enabled
// (R7) Tick pulse goes to wake-up unit
// (R8) New reload used only at next reload
// (R9) Restart reloads next edge, self clears
// (R10) Software waits for restart before sleep
// (R11) Watchdog 8-bit, disabled after reset
// (R12) Count or match write starts watchdog
// (R13) Clock select: tick pulse or prescaled
// (R14) Count write services; match writes ignored
// (R15) Match mode: 5Ch reloads programmed count
// (R16) Late or frequent service resets device
// (R17) Wrong match value resets device
// (R18) Locked register ignores writes, reads undefined
// (R19) Lock bits stick until reset
// (R20) Config layout: locks, select, service mode
// (R21) Timer lock covers reload and control
// (R22) Counters keep running in sleep modes
// (R23) Only match register reachable when sleeping
// (R24) Halt freezes unit, resumes exactly
// (R25) Software waits five slow clocks before sleep
// (R26) Power mode input qualifies register access
`timescale 1ns/1ps
`default_nettype none
module twu_timer_watchdog (
  input wire logic clock, // System clock, 100 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic slow_clock, // Slow clock pin, asynchronous
  input wire logic [1:0] power_mode, // Current device power mode
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic timer_tick_pulse, // Tick level towards wake-up unit
  output logic timer_interrupt_line, // Timer interrupt request
  output logic watchdog_reset // Watchdog error, resets device
);
  import twu_pkg::*;

  logic slow_sync1; // First synchroniser stage
  logic slow_sync2; // Second synchroniser stage
  logic slow_prev; // Delayed copy for edge detect
  logic slow_edge; // Slow clock rising edge, gated in halt
  logic prescaled_tick; // Prescaled clock edge pulse
  logic [CFG_WIDTH-1:0] config_q; // Configuration register
  logic [PRESCALE_WIDTH-1:0] prescale_select; // Prescaler field
  logic [15:0] reload_value; // Periodic reload value
  logic [15:0] timer_count; // Periodic down counter
  logic restart; // Pending restart request
  logic expired_flag; // Timer expired status
  logic irq_enable; // Timer interrupt enable
  logic tick_event; // Pulse when counter reaches zero
  logic [7:0] wd_count_reg; // Programmed watchdog count
  logic [7:0] wd_counter; // Running watchdog counter
  logic wd_started; // Watchdog running
  logic wd_serviced; // Serviced since last watchdog clock
  logic wd_clk_event; // Selected watchdog clock edge
  logic wd_service; // A service in this cycle
  logic wd_load; // Load counter in this cycle
  logic [7:0] wd_load_value; // Value to load
  logic wd_error; // Watchdog error condition
  logic access_phase; // APB access phase, awaiting answer
  logic do_write; // Write takes effect now
  logic sel_config; // Address decodes
  logic sel_prescaler;
  logic sel_reload;
  logic sel_ctrl;
  logic sel_wd_count;
  logic sel_wd_match;
  logic mapped; // Address hits a register
  logic allowed; // Register reachable now
  logic halted; // Device in halt mode
  logic [31:0] next_prdata; // Read data to register

  assign halted = (power_mode == TWU_HALT);

  // Slow clock synchroniser and edge detect
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      slow_sync1 <= 1'b0;
      slow_sync2 <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      slow_sync1 <= slow_clock;
      slow_sync2 <= slow_sync1;
      slow_prev <= slow_sync2;
    end
  end

  // (R24) Halt freezes all counting
  // (R22) Other modes keep counting
  assign slow_edge = slow_sync2 && !slow_prev && !halted;

  twu_prescaler u_prescaler (
    .clock(clock),
    .reset_n(reset_n),
    .slow_edge(slow_edge),
    .prescale_select(prescale_select),
    .prescaled_tick(prescaled_tick)
  );

  // Address decode on the full byte address
  assign sel_config = (paddr == ADDR_CONFIG);
  assign sel_prescaler = (paddr == ADDR_PRESCALER);
  assign sel_reload = (paddr == ADDR_RELOAD);
  assign sel_ctrl = (paddr == ADDR_CTRL_STATUS);
  assign sel_wd_count = (paddr == ADDR_WD_COUNT);
  assign sel_wd_match = (paddr == ADDR_WD_MATCH);
  assign mapped = sel_config || sel_prescaler || sel_reload || sel_ctrl ||
                  sel_wd_count || sel_wd_match;

  // Reachability of the addressed register
  always_comb begin
    allowed = 1'b1;
    // (R23) Sleep modes reach only the match register
    // (R26) Mode qualifies every access
    if (power_mode != TWU_ACTIVE) begin
      allowed = sel_wd_match && !halted;
    end
    // (R18) Locked registers are barred
    // (R21) Timer lock covers two registers
    if ((sel_config && config_q[CFG_LOCK_CONFIG]) ||
        (sel_prescaler && config_q[CFG_LOCK_PRESCALER]) ||
        ((sel_reload || sel_ctrl) && config_q[CFG_LOCK_TIMER]) ||
        (sel_wd_count && config_q[CFG_LOCK_WD_COUNT])) begin
      allowed = 1'b0;
    end
  end

  // Read data mux; barred reads give the undefined pattern
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (!mapped || !allowed) begin
      next_prdata = UNDEF_READ;
    end else if (sel_config) begin
      next_prdata = {26'h0, config_q};
    end else if (sel_prescaler) begin
      next_prdata = {29'h0, prescale_select};
    end else if (sel_reload) begin
      next_prdata = {16'h0000, reload_value};
    end else if (sel_ctrl) begin
      next_prdata = {29'h0, irq_enable, expired_flag, restart};
    end else if (sel_wd_count) begin
      next_prdata = {24'h000000, wd_count_reg};
    end
  end

  // Writes take effect on the edge where pready is seen high
  assign access_phase = psel && penable;
  assign do_write = access_phase && pready && pwrite && mapped && allowed;

  // APB answer: one wait cycle, outputs registered
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access_phase && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // (R20) Cleared at reset
      config_q <= CONFIG_RESET;
    end else if (do_write && sel_config) begin
      // (R19) Lock bits only ever set
      config_q[3:0] <= config_q[3:0] | pwdata[3:0];
      config_q[CFG_WD_CLOCK_SELECT] <= pwdata[CFG_WD_CLOCK_SELECT];
      config_q[CFG_MATCH_SERVICE] <= pwdata[CFG_MATCH_SERVICE];
    end
  end

  // Prescaler and reload registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prescale_select <= PRESCALE_RESET;
      reload_value <= RELOAD_RESET;
    end else begin
      if (do_write && sel_prescaler) begin
        prescale_select <= pwdata[PRESCALE_WIDTH-1:0];
      end
      // (R8) Stored only; counter picks it up at reload
      if (do_write && sel_reload) begin
        reload_value <= pwdata[15:0];
      end
    end
  end

  // Periodic down counter
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      timer_count <= RELOAD_RESET;
      tick_event <= 1'b0;
    end else begin
      tick_event <= 1'b0;
      if (prescaled_tick) begin
        if (restart) begin
          // (R9) Restart reloads on next edge
          timer_count <= reload_value;
        end else if (timer_count == 16'h0000) begin
          // (R3) Auto reload at zero
          timer_count <= reload_value;
        end else begin
          // (R2) Count down per edge
          timer_count <= timer_count - 16'h0001;
          tick_event <= (timer_count == 16'h0001);
        end
      end
    end
  end

  // Tick level, high from reaching zero to the next prescaled edge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      timer_tick_pulse <= 1'b0;
    end else if (tick_event) begin
      // (R5) One prescaled cycle long
      // (R7) Same level feeds the wake-up unit
      timer_tick_pulse <= 1'b1;
    end else if (prescaled_tick) begin
      timer_tick_pulse <= 1'b0;
    end
  end

  // Control status register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      restart <= 1'b0;
      expired_flag <= 1'b0;
      irq_enable <= 1'b0;
    end else begin
      if (do_write && sel_ctrl) begin
        irq_enable <= pwdata[CS_IRQ_ENABLE];
      end
      // (R9) Restart clears itself once done
      if (prescaled_tick && restart) begin
        restart <= 1'b0;
      end else if (do_write && sel_ctrl && pwdata[CS_RESTART]) begin
        restart <= 1'b1;
      end
      // (R6) Tick sets flag; set beats a clear
      if (tick_event) begin
        expired_flag <= 1'b1;
      end else if (do_write && sel_ctrl && pwdata[CS_EXPIRED]) begin
        expired_flag <= 1'b0;
      end
    end
  end

  // Interrupt request
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      timer_interrupt_line <= 1'b0;
    end else begin
      // (R6) Only when enabled
      timer_interrupt_line <= expired_flag && irq_enable;
    end
  end

  // (R13) Watchdog clock source select
  assign wd_clk_event = config_q[CFG_WD_CLOCK_SELECT] ? prescaled_tick : tick_event;

  // Watchdog service and load decisions
  always_comb begin
    wd_service = 1'b0;
    wd_load = 1'b0;
    wd_load_value = wd_count_reg;
    if (do_write && sel_wd_count) begin
      // (R14) Count write services in count mode
      wd_service = wd_started && !config_q[CFG_MATCH_SERVICE];
      wd_load = !wd_started || !config_q[CFG_MATCH_SERVICE];
      wd_load_value = pwdata[7:0];
    end else if (do_write && sel_wd_match) begin
      // (R15) Match code reloads programmed count
      wd_service = wd_started && config_q[CFG_MATCH_SERVICE] &&
                   (pwdata[7:0] == SERVICE_CODE);
      wd_load = !wd_started || wd_service;
    end
  end

  // Watchdog error sources
  always_comb begin
    wd_error = 1'b0;
    if (wd_started) begin
      // (R16) Too late or too often
      if ((wd_clk_event && wd_counter == 8'h00 && !wd_load) ||
          (wd_service && wd_serviced && !wd_clk_event)) begin
        wd_error = 1'b1;
      end
      // (R17) Wrong match value
      if (do_write && sel_wd_match && config_q[CFG_MATCH_SERVICE] &&
          pwdata[7:0] != SERVICE_CODE) begin
        wd_error = 1'b1;
      end
    end
  end

  // Watchdog counter
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // (R11) Disabled after reset
      wd_count_reg <= WD_COUNT_RESET;
      wd_counter <= WD_COUNT_RESET;
      wd_started <= 1'b0;
      wd_serviced <= 1'b0;
    end else begin
      if (do_write && sel_wd_count) begin
        wd_count_reg <= pwdata[7:0];
      end
      // (R12) Any count or match write starts it; never stops
      if (do_write && (sel_wd_count || sel_wd_match)) begin
        wd_started <= 1'b1;
      end
      if (wd_load) begin
        wd_counter <= wd_load_value;
      end else if (wd_started && wd_clk_event && wd_counter != 8'h00) begin
        wd_counter <= wd_counter - 8'h01;
      end
      wd_serviced <= wd_service || (wd_serviced && !wd_clk_event);
    end
  end

  // Error output holds until device reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      watchdog_reset <= 1'b0;
    end else if (wd_error) begin
      watchdog_reset <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence tick_at_zero_s;
    prescaled_tick && !restart && timer_count == 16'h0000;
  endsequence

  sequence tick_decrement_s;
    prescaled_tick && !restart && timer_count != 16'h0000;
  endsequence

  timer_reload_a: assert property (tick_at_zero_s |=> timer_count == $past(reload_value)) // R3
    else $error("timer did not reload at zero");
  timer_down_a: assert property (tick_decrement_s |=> timer_count == $past(timer_count) - 16'h0001) // R2
    else $error("timer did not count down");
  restart_done_a: assert property (prescaled_tick && restart |=> !restart && timer_count == $past(reload_value)) // R9
    else $error("restart not taken or not cleared");
  flag_set_a: assert property (tick_event |=> expired_flag ##1 timer_tick_pulse) // R6
    else $error("tick did not set flag");
  irq_gate_a: assert property (timer_interrupt_line |-> $past(irq_enable) && $past(expired_flag)) // R6
    else $error("interrupt without enable");
  wd_late_a: assert property (wd_started && wd_clk_event && wd_counter == 8'h00 && !wd_load |=> watchdog_reset) // R16
    else $error("late service not caught");
  bad_match_a: assert property (do_write && sel_wd_match && config_q[CFG_MATCH_SERVICE] && wd_started && pwdata[7:0] != SERVICE_CODE |=> watchdog_reset) // R17
    else $error("wrong match value not caught");
  wd_idle_a: assert property (!wd_started |=> !watchdog_reset) // R11
    else $error("idle watchdog raised error");
  lock_sticky_a: assert property (1'b1 |=> (config_q[3:0] & $past(config_q[3:0])) == $past(config_q[3:0])) // R19
    else $error("lock bit cleared");
  halt_freeze_a: assert property ((power_mode == TWU_HALT) [*3] |-> $stable(timer_count)) // R24
    else $error("timer moved in halt");
endmodule // twu_timer_watchdog
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the timing and watchdog unit.
// Assumes one APB wait state and a slow clock pin driven from here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import twu_pkg::*;
  localparam int SP = 20; // Slow clock period in system clocks
  typedef struct packed {logic chk; logic err; logic [31:0] data;} twu_note_t;
  logic clock = 1'b0; // System clock
  logic reset_n = 1'b0; // Active low reset
  logic slow_clock = 1'b0; // Slow clock pin
  logic [1:0] power_mode = 2'b00; // Power mode
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata; // APB data path
  logic pready, pslverr, timer_tick_pulse, timer_interrupt_line, watchdog_reset;
  logic tick_d = 1'b0; // Tick level one clock ago
  int fails = 0, total_checks = 0, cyc = 0, sdiv = 0;
  int rises[$]; // Clock counts at tick rises
  twu_note_t notes[$]; // Expected bus answers, oldest first
  twu_note_t seen;
  logic [7:0] bad;

  twu_timer_watchdog uut (
    .clock(clock), .reset_n(reset_n), .slow_clock(slow_clock), .power_mode(power_mode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick_pulse(timer_tick_pulse),
    .timer_interrupt_line(timer_interrupt_line), .watchdog_reset(watchdog_reset)
  );

  always #5 clock = ~clock;

  // Slow pin locked to clock, so tick spacing is exact
  always @(posedge clock) begin
    sdiv <= (sdiv == SP / 2 - 1) ? 0 : sdiv + 1;
    if (sdiv == SP / 2 - 1) begin
      slow_clock <= ~slow_clock;
    end
  end

  // Log every rising edge of the tick level
  always @(posedge clock) begin
    cyc <= cyc + 1;
    tick_d <= timer_tick_pulse;
    if (timer_tick_pulse === 1'b1 && tick_d === 1'b0) begin
      rises.push_back(cyc);
    end
  end

  // Bus watcher: every answer consumes the oldest note
  always @(posedge clock) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("Error apb_answer expected none seen %h", prdata);
      end else begin
        seen = notes.pop_front();
        check_bus(seen, pslverr, prdata);
      end
    end
  end

  task automatic check_bus(input twu_note_t e, input logic err, input logic [31:0] d);
    total_checks++;
    if (err !== e.err || (e.chk && d !== e.data)) begin
      fails++;
      $display("Error apb_answer expected %b/%h seen %b/%h", e.err, e.data, err, d);
    end
  endtask

  task automatic check_span(input string name, input int exp, input int got);
    total_checks++;
    if (exp != got) begin
      fails++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic err, input logic chk, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clock);
    notes.push_back(twu_note_t'{chk, err, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0, 1'b1, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic do_reset();
    @(posedge clock);
    reset_n <= 1'b0;
    idle(5);
    reset_n <= 1'b1;
  endtask

  // Bounded wait for n logged tick rises
  task automatic wait_rises(input int n);
    int k;
    k = 0;
    while (rises.size() < n && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (rises.size() < n) begin
      fails++;
      conclude();
    end
  endtask

  // Settled tick period; the first, partial interval is skipped
  task automatic span(input int exp);
    rises.delete();
    wait_rises(3);
    check_span("tick_period", exp, rises[2] - rises[1]);
  endtask

  initial begin
    int r;
    void'($urandom(32'h6af7));
    do_reset();
    rd(ADDR_CONFIG, 32'h0);
    rd(ADDR_PRESCALER, 32'h0);
    rd(ADDR_RELOAD, 32'hffff);
    rd(ADDR_CTRL_STATUS, 32'h0);
    rd(ADDR_WD_COUNT, 32'h0);
    apb(1'b0, 32'h03fffcb0, 32'h0, 1'b1, 1'b1, 32'h0);
    // Restart loads the short reload, bit self clears
    wr(ADDR_RELOAD, 32'h1);
    wr(ADDR_CTRL_STATUS, 32'h1);
    idle(100);
    rd(ADDR_CTRL_STATUS, 32'h2);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_PRESCALER, 32'(k));
      span(2 * (1 << k) * SP);
    end
    wr(ADDR_PRESCALER, 32'h0);
    r = 1 + $urandom % 6;
    wr(ADDR_RELOAD, 32'(r));
    span((r + 1) * SP);
    // New reload only after the current period ends
    wr(ADDR_RELOAD, 32'h40);
    rises.delete();
    wait_rises(1);
    // Write lands well inside the long period
    idle(10 * SP);
    wr(ADDR_RELOAD, 32'h3);
    wait_rises(3);
    check_span("old_reload_period", 65 * SP, rises[1] - rises[0]);
    check_span("new_reload_period", 4 * SP, rises[2] - rises[1]);
    // Flag always set, line only when enabled
    wr(ADDR_CTRL_STATUS, 32'h2);
    rises.delete();
    wait_rises(1);
    idle(3);
    check_flag("irq_masked", 1'b0, timer_interrupt_line);
    rd(ADDR_CTRL_STATUS, 32'h2);
    wr(ADDR_CTRL_STATUS, 32'h6);
    rises.delete();
    wait_rises(1);
    idle(3);
    check_flag("irq_line", 1'b1, timer_interrupt_line);
    wr(ADDR_CTRL_STATUS, 32'h6);
    rd(ADDR_CTRL_STATUS, 32'h4);
    check_flag("irq_cleared", 1'b0, timer_interrupt_line);
    // Sleep modes keep counting but bar most registers
    // Restart long completed
    power_mode <= TWU_POWER_SAVE;
    span(4 * SP);
    rd(ADDR_RELOAD, 32'h0);
    wr(ADDR_RELOAD, 32'h9);
    power_mode <= TWU_IDLE;
    rd(ADDR_CTRL_STATUS, 32'h0);
    power_mode <= TWU_ACTIVE;
    rd(ADDR_RELOAD, 32'h3);
    // Halt of exactly ten slow periods stretches one interval
    rises.delete();
    wait_rises(1);
    idle(20);
    power_mode <= TWU_HALT;
    idle(10 * SP);
    power_mode <= TWU_ACTIVE;
    wait_rises(2);
    check_span("halt_resume", 14 * SP, rises[1] - rises[0]);
    check_flag("wd_stopped", 1'b0, watchdog_reset);
    // Late service on the prescaled clock
    wr(ADDR_CONFIG, 32'h10);
    wr(ADDR_WD_COUNT, 32'h5);
    idle(60);
    check_flag("wd_early", 1'b0, watchdog_reset);
    idle(100);
    check_flag("wd_late", 1'b1, watchdog_reset);
    do_reset();
    // Tick pulse as watchdog clock is far slower
    wr(ADDR_RELOAD, 32'h3);
    wr(ADDR_CTRL_STATUS, 32'h1);
    wr(ADDR_WD_COUNT, 32'h2);
    idle(150);
    check_flag("wd_tick_clock", 1'b0, watchdog_reset);
    idle(300);
    check_flag("wd_tick_late", 1'b1, watchdog_reset);
    do_reset();
    // Count servicing; match writes ignored; double service
    wr(ADDR_PRESCALER, 32'h5);
    wr(ADDR_CONFIG, 32'h10);
    wr(ADDR_WD_COUNT, 32'h30);
    idle(700);
    wr(ADDR_WD_COUNT, 32'h30);
    idle(700);
    wr(ADDR_WD_MATCH, 32'h12);
    idle(10);
    check_flag("wd_match_ignored", 1'b0, watchdog_reset);
    wr(ADDR_WD_COUNT, 32'h30);
    wr(ADDR_WD_COUNT, 32'h30);
    idle(10);
    check_flag("wd_too_often", 1'b1, watchdog_reset);
    do_reset();
    // Match servicing, then a wrong code
    wr(ADDR_CONFIG, 32'h30);
    wr(ADDR_WD_COUNT, 32'h8);
    repeat (3) begin
      idle(60);
      wr(ADDR_WD_MATCH, {24'h0, SERVICE_CODE});
    end
    check_flag("wd_match_service", 1'b0, watchdog_reset);
    bad = 8'($urandom);
    if (bad == SERVICE_CODE) begin
      bad = 8'h00;
    end
    wr(ADDR_WD_MATCH, {24'h0, bad});
    idle(10);
    check_flag("wd_bad_code", 1'b1, watchdog_reset);
    do_reset();
    // Locks stick and hide their registers
    // Nonzero contents so that hidden reads differ
    wr(ADDR_WD_COUNT, 32'h77);
    wr(ADDR_CTRL_STATUS, 32'h4);
    wr(ADDR_CONFIG, 32'h3e);
    rd(ADDR_CONFIG, 32'h3e);
    wr(ADDR_PRESCALER, 32'h3);
    rd(ADDR_PRESCALER, 32'h0);
    rd(ADDR_RELOAD, 32'h0);
    rd(ADDR_CTRL_STATUS, 32'h0);
    rd(ADDR_WD_COUNT, 32'h0);
    wr(ADDR_CONFIG, 32'h30);
    rd(ADDR_CONFIG, 32'h3e);
    wr(ADDR_CONFIG, 32'h31);
    rd(ADDR_CONFIG, 32'h0);
    do_reset();
    rd(ADDR_CONFIG, 32'h0);
    rd(ADDR_RELOAD, 32'hffff);
    idle(5);
    conclude();
  end

  // Hang guard, far above the expected run length
  initial begin
    #1_000_000;
    fails++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
